//--- core/add_and_logic_ops.sv
// Avalon-MM register front end around the add and logic datapath.
`timescale 1ns/10ps

//
// Contract
// RULE1 - Add into memory adds the working register to the addressed byte, stores the sum there and updates overflow, zero, nibble carry, carry and signed result flags.
// RULE2 - AND with memory puts the working register AND the addressed byte into the working register and updates only the zero flag.
// RULE3 - AND with immediate puts the working register AND the immediate into the working register and updates only the zero flag.
// RULE4 - AND into memory writes the addressed byte AND the working register back to that byte and leaves the working register alone.
// RULE5 - The zero flag is set exactly when the stored result is zero, and flags an operation does not name keep their value.
module add_and_logic_ops (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Avalon-MM slave
	input wire logic [alu_pkg::ADDR_W-1:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [3:0] BYTEENABLE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST
);
	import alu_pkg::*;

	logic [DATA_W-1:0] working_register;
	logic [FLAG_W-1:0] flags;
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic [31:0] last_instr;
	logic [31:0] next_instr;
	logic access;
	logic wr_go;
	logic exec;
	alu_op_t op;
	logic [MEM_ADDR_W-1:0] op_addr;
	logic [DATA_W-1:0] op_imm;
	logic [DATA_W-1:0] result;
	logic [FLAG_W-1:0] next_flags;
	logic to_memory;

	// ==========================================================
	// Address decode
	function automatic logic is_mem(input logic [ADDR_W-1:0] a);
		return (a >= OFS_MEM_BASE) && (a <= OFS_MEM_LAST) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [MEM_ADDR_W-1:0] mem_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - OFS_MEM_BASE;
		return rel[MEM_ADDR_W+1:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] be);
		logic [31:0] m;
		m = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// An access completes in the cycle its waitrequest is low.
	assign access = (READ || WRITE) && !WAITREQUEST;
	assign wr_go = WRITE && !WAITREQUEST;
	assign exec = wr_go && (ADDRESS == OFS_INSTR);

	// Unwritten lanes of the instruction word keep the previous instruction's fields.
	assign next_instr = merge(last_instr, WRITEDATA, BYTEENABLE);
	assign op = alu_op_t'(next_instr[INSTR_OP_LSB +: 2]);
	assign op_addr = next_instr[INSTR_ADDR_LSB +: MEM_ADDR_W];
	assign op_imm = next_instr[INSTR_IMM_LSB +: DATA_W];

	alu_core u_alu (
		.op(op),
		.working_register(working_register),
		.mem_byte(mem[op_addr]),
		.immediate(op_imm),
		.flags(flags),
		.result(result),
		.next_flags(next_flags),
		.to_memory(to_memory)
	);

	// ==========================================================
	// Bus handshake: one wait cycle per access, then one cycle with waitrequest low.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			WAITREQUEST <= 1'b1;
		end else if ((READ || WRITE) && WAITREQUEST) begin
			WAITREQUEST <= 1'b0;
		end else begin
			WAITREQUEST <= 1'b1;
		end
	end

	// Read data is loaded one cycle early so it stands at the completing edge.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			READDATA <= WORD_RESET;
		end else if (READ && WAITREQUEST) begin
			READDATA <= WORD_RESET;
			if (ADDRESS == OFS_WORKING) begin
				READDATA[DATA_W-1:0] <= working_register;
			end else if (ADDRESS == OFS_FLAGS) begin
				READDATA[FLAG_W-1:0] <= flags;
			end else if (ADDRESS == OFS_LAST) begin
				READDATA <= last_instr;
			end else if (is_mem(ADDRESS)) begin
				READDATA[DATA_W-1:0] <= mem[mem_index(ADDRESS)];
			end
		end
	end

	// ==========================================================
	// Working register
	always_ff @(posedge CLK) begin
		if (RESET) begin
			working_register <= WORKING_RESET;
		end else if (exec && !to_memory) begin
			working_register <= result; // RULE2 RULE3
		end else if (wr_go && ADDRESS == OFS_WORKING && BYTEENABLE[0]) begin
			working_register <= WRITEDATA[DATA_W-1:0];
		end
	end

	// ==========================================================
	// Status flags
	always_ff @(posedge CLK) begin
		if (RESET) begin
			flags <= FLAGS_RESET;
		end else if (exec) begin
			flags <= next_flags; // RULE5
		end else if (wr_go && ADDRESS == OFS_FLAGS && BYTEENABLE[0]) begin
			flags <= WRITEDATA[FLAG_W-1:0];
		end
	end

	// ==========================================================
	// Last executed instruction
	always_ff @(posedge CLK) begin
		if (RESET) begin
			last_instr <= WORD_RESET;
		end else if (exec) begin
			last_instr <= next_instr;
		end
	end

	// ==========================================================
	// Data memory
	generate
		for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_mem
			always_ff @(posedge CLK) begin
				if (RESET) begin
					mem[g] <= ZERO_BYTE;
				end else if (exec && to_memory && op_addr == MEM_ADDR_W'(g)) begin
					mem[g] <= result; // RULE1 RULE4
				end else if (wr_go && is_mem(ADDRESS) && BYTEENABLE[0] &&
					mem_index(ADDRESS) == MEM_ADDR_W'(g)) begin
					mem[g] <= WRITEDATA[DATA_W-1:0];
				end
			end
		end
	endgenerate

endmodule // add_and_logic_ops

//--- core/alu_pkg.sv
// Shared constants, register map and operation codes of the add and logic datapath.
package alu_pkg;

	// ==========================================================
	// Widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int MEM_ADDR_W = 4;
	localparam int MEM_DEPTH = 16;

	// ==========================================================
	// Register byte offsets on the Avalon slave
	localparam logic [ADDR_W-1:0] OFS_WORKING = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_LAST = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_MEM_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_MEM_LAST = 8'h7C;

	// ==========================================================
	// Flag bit positions in the flags register
	localparam int FLAG_W = 5;
	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_SC = 4;

	// ==========================================================
	// Instruction word fields
	localparam int INSTR_OP_LSB = 0;
	localparam int INSTR_ADDR_LSB = 8;
	localparam int INSTR_IMM_LSB = 16;
	localparam int NIBBLE_MSB = 3;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] WORKING_RESET = 8'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
	localparam logic [31:0] WORD_RESET = 32'h00000000;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	typedef enum logic [1:0] {
		OP_ADD_INTO_MEMORY = 2'b00,
		OP_AND_WITH_MEMORY = 2'b01,
		OP_AND_WITH_IMMEDIATE = 2'b10,
		OP_AND_INTO_MEMORY = 2'b11
	} alu_op_t;

endpackage

//--- core/alu_core.sv
// Combinational add and AND datapath with status flag update.
`timescale 1ns/10ps

module alu_core (
	// Operation select
	input wire alu_pkg::alu_op_t op,
	// Operands
	input wire logic [alu_pkg::DATA_W-1:0] working_register,
	input wire logic [alu_pkg::DATA_W-1:0] mem_byte,
	input wire logic [alu_pkg::DATA_W-1:0] immediate,
	input wire logic [alu_pkg::FLAG_W-1:0] flags,
	// Results
	output logic [alu_pkg::DATA_W-1:0] result,
	output logic [alu_pkg::FLAG_W-1:0] next_flags,
	output logic to_memory
);
	import alu_pkg::*;

	logic [DATA_W:0] sum;
	logic [NIBBLE_MSB+1:0] low_sum;
	logic [DATA_W-1:0] conj;
	logic overflow;

	assign sum = {1'b0, working_register} + {1'b0, mem_byte};
	assign low_sum = {1'b0, working_register[NIBBLE_MSB:0]} + {1'b0, mem_byte[NIBBLE_MSB:0]};
	assign overflow = (working_register[DATA_W-1] == mem_byte[DATA_W-1]) &&
		(sum[DATA_W-1] != working_register[DATA_W-1]);

	always_comb begin
		conj = working_register & mem_byte;
		result = conj;
		next_flags = flags;
		to_memory = 1'b0;
		unique case (op)
			OP_ADD_INTO_MEMORY: begin
				result = sum[DATA_W-1:0]; // RULE1
				to_memory = 1'b1; // RULE1
				next_flags[FLAG_C] = sum[DATA_W]; // RULE1
				next_flags[FLAG_AC] = low_sum[NIBBLE_MSB+1]; // RULE1
				next_flags[FLAG_OV] = overflow; // RULE1
				// Signed result: true sign of the sum even when it overflowed.
				next_flags[FLAG_SC] = overflow ^ sum[DATA_W-1]; // RULE1
			end
			OP_AND_WITH_MEMORY: begin
				result = conj; // RULE2
			end
			OP_AND_WITH_IMMEDIATE: begin
				result = working_register & immediate; // RULE3
			end
			OP_AND_INTO_MEMORY: begin
				result = conj; // RULE4
				to_memory = 1'b1; // RULE4
			end
		endcase
		// Every operation here updates the zero flag; flags an operation does not set keep their value.
		next_flags[FLAG_Z] = (result == ZERO_BYTE); // RULE5
	end

endmodule // alu_core

//--- verif/add_and_logic_ops_props.sv
// Port-level protocol checks for the add and logic front end.
`timescale 1ns/10ps

module add_and_logic_ops_props
	import alu_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [3:0] BYTEENABLE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [31:0] READDATA,
	input wire logic WAITREQUEST
);
	// ====
	// Handshake and read data
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	wire rd_done = READ && !WAITREQUEST;
	a_answer_next: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
		else $error("answer late");
	a_single_pulse: assert property (!WAITREQUEST |=> WAITREQUEST) else $error("wait low too long");
	a_answer_cause: assert property (!WAITREQUEST |-> $past(READ || WRITE)) else $error("spurious answer");
	a_idle_wait: assert property (!READ && !WRITE && WAITREQUEST |=> WAITREQUEST) else $error("idle answer");
	a_rdata_stands: assert property (!READ |=> $stable(READDATA)) else $error("read data moved");
	a_flags_width: assert property (rd_done && ADDRESS == OFS_FLAGS |-> READDATA[31:FLAG_W] == 0)
		else $error("flag upper bits set");
	a_instr_reads: assert property (rd_done && ADDRESS == OFS_INSTR |-> READDATA == 0)
		else $error("instruction read not zero");
	a_unmapped_zero: assert property (rd_done && ADDRESS == 8'h10 |-> READDATA == 0)
		else $error("unmapped read not zero");
	c_instr: cover property (WRITE && !WAITREQUEST && ADDRESS == OFS_INSTR);
	c_flags: cover property (rd_done && ADDRESS == OFS_FLAGS);
	c_mem: cover property (rd_done && ADDRESS >= OFS_MEM_BASE);
endmodule // add_and_logic_ops_props

//--- verif/add_and_logic_ops_bench.sv
// Self-checking bench for the add and logic front end.
`timescale 1ns/10ps

module add_and_logic_ops_bench;
	import alu_pkg::*;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic [7:0] ADDRESS = 8'h00;
	logic READ = 1'b0;
	logic WRITE = 1'b0;
	logic [3:0] BYTEENABLE = 4'hF;
	logic [31:0] WRITEDATA = 32'h00000000;
	logic [31:0] READDATA;
	logic WAITREQUEST;
	int errors = 0;
	int cmp_count = 0;
	always #5 CLK = ~CLK;
	add_and_logic_ops uut (.CLK(CLK), .RESET(RESET), .ADDRESS(ADDRESS), .READ(READ),
		.WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA),
		.READDATA(READDATA), .WAITREQUEST(WAITREQUEST));
	// ====
	// Bus tasks
	task automatic access(input logic [7:0] a, input logic [31:0] d, input logic w,
		output logic [31:0] q);
		ADDRESS <= a;
		WRITEDATA <= d;
		WRITE <= w;
		READ <= !w;
		// Only the watchdog ends a wait that never completes.
		do begin
			@(posedge CLK);
		end while (WAITREQUEST !== 1'b0);
		q = READDATA;
		WRITE <= 1'b0;
		READ <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		access(a, d, 1'b1, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		access(a, 32'h00000000, 1'b0, q);
		cmp_count++;
		if (q !== e) begin
			errors++;
			$display("mismatch addr %h expected %h seen %h", a, e, q);
		end
	endtask
	// Loads operands, executes one instruction, then reads back all three results.
	task automatic run(input logic [1:0] op, input logic [3:0] i, input logic [7:0] w, m, imm,
		input logic [4:0] f, input logic [7:0] ew, em, input logic [4:0] ef);
		wr(OFS_WORKING, {24'h000000, w});
		wr(OFS_FLAGS, {27'h0000000, f});
		wr({2'b01, i, 2'b00}, {24'h000000, m});
		wr(OFS_INSTR, {8'h00, imm, 4'h0, i, 6'h00, op});
		rd(OFS_WORKING, {24'h000000, ew});
		rd({2'b01, i, 2'b00}, {24'h000000, em});
		rd(OFS_FLAGS, {27'h0000000, ef});
	endtask
	task automatic finish_test();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ====
	// Tests
	initial begin
		repeat (20) @(posedge CLK);
		RESET <= 1'b0;
		rd(OFS_WORKING, 32'h00000000);
		rd(OFS_FLAGS, 32'h00000000);
		rd(OFS_MEM_LAST, 32'h00000000);
		wr(8'h10, 32'h000000FF);
		rd(8'h10, 32'h00000000);
		rd(OFS_INSTR, 32'h00000000);
		run(OP_ADD_INTO_MEMORY, 4'h3, 8'h8F, 8'h71, 8'h00, 5'h00, 8'h8F, 8'h00, 5'h07);
		run(OP_ADD_INTO_MEMORY, 4'h9, 8'h40, 8'h40, 8'h00, 5'h1F, 8'h40, 8'h80, 5'h08);
		run(OP_ADD_INTO_MEMORY, 4'h0, 8'h80, 8'h80, 8'h00, 5'h00, 8'h80, 8'h00, 5'h1D);
		run(OP_AND_WITH_MEMORY, 4'h5, 8'hF0, 8'h0F, 8'h00, 5'h1B, 8'h00, 8'h0F, 5'h1F);
		run(OP_AND_WITH_IMMEDIATE, 4'h6, 8'h3C, 8'h55, 8'hA5, 5'h1F, 8'h24, 8'h55, 5'h1B);
		run(OP_AND_INTO_MEMORY, 4'hF, 8'h3C, 8'hF3, 8'h00, 5'h04, 8'h3C, 8'h30, 5'h00);
		rd(OFS_LAST, 32'h00000F03);
		finish_test();
	end
	initial begin
		repeat (3000) @(posedge CLK);
		errors++;
		finish_test();
	end
endmodule // add_and_logic_ops_bench

bind add_and_logic_ops add_and_logic_ops_props props (.CLK(CLK), .RESET(RESET),
	.ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE),
	.WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST));
